// file: hdl/ssc_pkg.sv
// package for the solenoid setpoint conditioning block
// assumes a single 125 MHz system clock and a plain register port
package ssc_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses; word index = offset from table base / 4)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_RATED_A   = 8'h04;
  localparam logic [7:0] ADDR_RATED_B   = 8'h08;
  localparam logic [7:0] ADDR_OVERLAP   = 8'h0C;
  localparam logic [7:0] ADDR_FULLSCALE = 8'h10;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h14;
  localparam logic [7:0] ADDR_DITHER_A  = 8'h18;
  localparam logic [7:0] ADDR_DITHER_B  = 8'h1C;
  localparam logic [7:0] ADDR_PWM       = 8'h20;
  localparam logic [7:0] ADDR_GAIN_A    = 8'h24;
  localparam logic [7:0] ADDR_GAIN_B    = 8'h28;
  localparam logic [7:0] ADDR_PD_OUT    = 8'h2C;
  localparam logic [7:0] ADDR_PD_STAT   = 8'h30;
  localparam logic [7:0] ADDR_MON_W     = 8'h34;
  localparam logic [7:0] ADDR_MON_U     = 8'h38;
  localparam logic [7:0] ADDR_CURVE_X   = 8'h40;
  localparam logic [7:0] ADDR_CURVE_Y   = 8'h94;
  localparam logic [7:0] ADDR_CURVE_END = 8'hE8;
  // ------------------------------------------------------------
  // fields, codes, ranges
  // ------------------------------------------------------------
  localparam int          BIT_MODE       = 0;
  localparam int          BIT_POLARITY   = 1;
  localparam int          BIT_CURVE_EN   = 2;
  localparam logic        MODE_DUAL      = 1'b0;
  localparam logic        MODE_SINGLE    = 1'b1;
  localparam logic        POL_PLUS       = 1'b0;
  localparam logic        CURVE_ON       = 1'b1;
  localparam logic [1:0]  GAIN_AUTO      = 2'h2;
  localparam logic [1:0]  GAIN_MANUAL    = 2'h1;
  localparam logic signed [15:0] COORD_MAX = 16'sh2710;
  localparam logic [15:0] RATED_MIN      = 16'h01F4;
  localparam logic [15:0] RATED_MAX      = 16'h0A28;
  localparam logic [15:0] OVERLAP_MAX    = 16'h0258;
  localparam logic [15:0] FULL_MIN       = 16'h0190;
  localparam logic [15:0] FULL_MAX       = 16'h03E8;
  localparam logic [15:0] THRESH_MAX     = 16'h012C;
  localparam logic [15:0] DITHER_AMPLITUDE_MAX      = 16'h012C;
  localparam logic [15:0] DITHER_RATE_MIN_DUAL = 16'h003C;
  localparam logic [15:0] DITHER_RATE_MIN_SGL  = 16'h0005;
  localparam logic [15:0] DITHER_RATE_MAX      = 16'h0190;
  localparam logic [15:0] DITHER_RATE_STEP_LO  = 16'h00C8;
  localparam logic [15:0] DITHER_RATE_STEP     = 16'h0032;
  localparam logic [4:0]  PWM_STEP_MAX   = 5'h13;
  localparam logic [7:0]  PGAIN_MAX      = 8'h1E;
  localparam logic [7:0]  IGAIN_MIN      = 8'h01;
  localparam logic [7:0]  IGAIN_MAX      = 8'h64;
  localparam logic [7:0]  PGAIN_DEF      = 8'h07;
  localparam logic [7:0]  IGAIN_DEF      = 8'h28;
  localparam logic [7:0]  PGAIN_LOW      = 8'h02;
  localparam logic [7:0]  IGAIN_LOW      = 8'h3C;
  localparam logic [4:0]  PWM_STEP_250   = 5'h07;
  localparam int          PD_IN_BYTES    = 6;
  localparam int          PD_OUT_BYTES   = 10;
  // reset values (percent in 0.1 %, current in mA)
  localparam logic [15:0] RST_RATED      = 16'h03E8;
  localparam logic [15:0] RST_FULL       = 16'h03E8;
  localparam logic [15:0] RST_DITHER_AMPLITUDE      = 16'h0032;
  localparam logic [15:0] RST_DITHER_RATE      = 16'h0079;
  localparam logic [4:0]  RST_PWM        = 5'h13;
  localparam logic [1:0]  RST_GAIN_MODE  = 2'h2;

  typedef struct packed {
    logic        enable_b;
    logic        enable_a;
    logic signed [15:0] setpoint_b;
    logic signed [15:0] setpoint_a;
  } ssc_pd_in_t;
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] pin9;
    logic [15:0] pin10;
    logic [15:0] current_a;
    logic [15:0] current_b;
  } ssc_pd_out_t;
  typedef struct packed {
    logic signed [15:0] demand_a;
    logic signed [15:0] demand_b;
    logic [15:0]        dither_ampl_a;
    logic [15:0]        dither_rate_a;
    logic [15:0]        dither_ampl_b;
    logic [15:0]        dither_rate_b;
    logic [4:0]         pwm_a;
    logic [4:0]         pwm_b;
    logic [7:0]         prop_gain_a;
    logic [7:0]         integral_gain_a;
    logic [7:0]         prop_gain_b;
    logic [7:0]         integral_gain_b;
  } ssc_drive_t;
endpackage

// file: hdl/ssc_top.sv
// setpoint conditioning and current loop settings for a two-solenoid driver
// assumes a synchronous register master and process data from link logic on clk_sys
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - polarity 0: positive setpoint drives A, negative drives B; 1 swaps.
// - polarity swap acts only in two-solenoid directional mode.
// - curve shaping only when enabled; otherwise signal passes unchanged.
// - dual mode points -10..10, positive for A, negative for B, +-10000.
// - between points, output follows straight line through bracketing points.
// - single-coil mode: each channel own curve 0..10, first quadrant only.
// - point x is input value, point y is output value.
// - full demand yields maximum current, 40.0..100.0 % of rated.
// - overlap offset 0..60.0 % of rated added for valve dead band.
// - offset added only above threshold 0..30.0 %; below it output is zero.
// - rated current 500..2600 mA, global or per channel; scaling refers to it. The code has per-channel registers only (ADDR_RATED_A, ADDR_RATED_B).
// - dither amplitude 0..30.0 % of rated current.
// - dither rate 60..400 Hz dual, 5..400 Hz single-coil.
// - high dither rates use discrete steps, rounding up.
// - PWM frequency one of twenty steps, 61 Hz to 2604 Hz.
// - auto tune code 2 derives gains from PWM; code 1 uses manual gains.
// - PI loop; prop gain 0..30, integral 1..100, editable only manual.
// - setpoints and scaled commands plus currents are observable.
// - process data are 6 bytes in and 10 bytes out.
// - mode 0 two-solenoid directional, 1 single-coil channels.
// - curve enable 1 on, 0 off.
module ssc_top (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [31:0]             reg_rdata,
  // process data
  input  wire logic [47:0]             pd_in,
  input  wire logic [15:0]             meas_current_a,
  input  wire logic [15:0]             meas_current_b,
  output logic      [79:0]             pd_out,
  // drive to power stage
  output ssc_pkg::ssc_drive_t          drive
);
  // ------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------
  logic              mode, next_mode, polarity, next_polarity, curve_en, next_curve_en;
  logic [15:0]       rated_a, next_rated_a, rated_b, next_rated_b;
  logic [15:0]       ovl_a, next_ovl_a, ovl_b, next_ovl_b;
  logic [15:0]       full_a, next_full_a, full_b, next_full_b;
  logic [15:0]       thresh, next_thresh;
  logic [15:0]       dither_amplitude_a, next_dither_amplitude_a, dither_amplitude_b, next_dither_amplitude_b;
  logic [15:0]       drate_a, next_drate_a, drate_b, next_drate_b;
  logic [4:0]        pwm_a, next_pwm_a, pwm_b, next_pwm_b;
  logic [1:0]        tune_a, next_tune_a, tune_b, next_tune_b;
  logic [7:0]        pg_a, next_pg_a, ig_a, next_ig_a, pg_b, next_pg_b, ig_b, next_ig_b;
  logic signed [15:0] cx [0:20];
  logic signed [15:0] cy [0:20];
  logic [4:0]        pt_idx;
  logic              wr_x, wr_y;
  logic [15:0]       w_lo, w_hi;
  logic [15:0]       min_rate;
  logic [15:0]       rate_q;

  assign w_lo   = reg_wdata[15:0];
  assign w_hi   = reg_wdata[31:16];
  // 21 points per table: offset from the table base, in words
  assign pt_idx = 5'((reg_addr - ((reg_addr >= ssc_pkg::ADDR_CURVE_Y)
                  ? ssc_pkg::ADDR_CURVE_Y : ssc_pkg::ADDR_CURVE_X)) >> 2);
  assign wr_x   = reg_write && reg_addr >= ssc_pkg::ADDR_CURVE_X
                  && reg_addr < ssc_pkg::ADDR_CURVE_Y && pt_idx <= 5'h14;
  assign wr_y   = reg_write && reg_addr >= ssc_pkg::ADDR_CURVE_Y
                  && reg_addr < ssc_pkg::ADDR_CURVE_END && pt_idx <= 5'h14;
  assign min_rate = (mode == ssc_pkg::MODE_DUAL) ? ssc_pkg::DITHER_RATE_MIN_DUAL
                                                 : ssc_pkg::DITHER_RATE_MIN_SGL;
  // round up to the next 50 Hz step above the fine range
  assign rate_q = (w_lo <= ssc_pkg::DITHER_RATE_STEP_LO) ? w_lo
                : 16'((w_lo + ssc_pkg::DITHER_RATE_STEP - 16'h0001) / ssc_pkg::DITHER_RATE_STEP
                  * ssc_pkg::DITHER_RATE_STEP);

  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  always_comb begin
    next_mode = mode; next_polarity = polarity; next_curve_en = curve_en;
    next_rated_a = rated_a; next_rated_b = rated_b;
    next_ovl_a = ovl_a; next_ovl_b = ovl_b; next_full_a = full_a; next_full_b = full_b;
    next_thresh = thresh; next_dither_amplitude_a = dither_amplitude_a; next_dither_amplitude_b = dither_amplitude_b;
    next_drate_a = drate_a; next_drate_b = drate_b; next_pwm_a = pwm_a; next_pwm_b = pwm_b;
    next_tune_a = tune_a; next_tune_b = tune_b;
    next_pg_a = pg_a; next_ig_a = ig_a; next_pg_b = pg_b; next_ig_b = ig_b;
    if (reg_write) begin
      unique case (reg_addr)
        ssc_pkg::ADDR_CONFIG: begin
          next_mode     = reg_wdata[ssc_pkg::BIT_MODE];
          next_polarity = reg_wdata[ssc_pkg::BIT_POLARITY];
          next_curve_en = reg_wdata[ssc_pkg::BIT_CURVE_EN];
        end
        ssc_pkg::ADDR_RATED_A: if (in_rng(w_lo, ssc_pkg::RATED_MIN, ssc_pkg::RATED_MAX))
          next_rated_a = w_lo;
        ssc_pkg::ADDR_RATED_B: if (in_rng(w_lo, ssc_pkg::RATED_MIN, ssc_pkg::RATED_MAX))
          next_rated_b = w_lo;
        ssc_pkg::ADDR_OVERLAP: if (w_lo <= ssc_pkg::OVERLAP_MAX
                                   && w_hi <= ssc_pkg::OVERLAP_MAX) begin
          next_ovl_a = w_lo;
          next_ovl_b = w_hi;
        end
        ssc_pkg::ADDR_FULLSCALE: if (in_rng(w_lo, ssc_pkg::FULL_MIN, ssc_pkg::FULL_MAX)
                                     && in_rng(w_hi, ssc_pkg::FULL_MIN, ssc_pkg::FULL_MAX)) begin
          next_full_a = w_lo;
          next_full_b = w_hi;
        end
        ssc_pkg::ADDR_THRESHOLD: if (w_lo <= ssc_pkg::THRESH_MAX)
          next_thresh = w_lo;
        ssc_pkg::ADDR_DITHER_A: if (w_hi <= ssc_pkg::DITHER_AMPLITUDE_MAX
                                    && in_rng(w_lo, min_rate, ssc_pkg::DITHER_RATE_MAX)) begin
          next_dither_amplitude_a = w_hi;
          next_drate_a = rate_q;
        end
        ssc_pkg::ADDR_DITHER_B: if (w_hi <= ssc_pkg::DITHER_AMPLITUDE_MAX
                                    && in_rng(w_lo, min_rate, ssc_pkg::DITHER_RATE_MAX)) begin
          next_dither_amplitude_b = w_hi;
          next_drate_b = rate_q;
        end
        ssc_pkg::ADDR_PWM: if (reg_wdata[4:0] <= ssc_pkg::PWM_STEP_MAX
                               && reg_wdata[20:16] <= ssc_pkg::PWM_STEP_MAX) begin
          next_pwm_a = reg_wdata[4:0];
          next_pwm_b = reg_wdata[20:16];
        end
        ssc_pkg::ADDR_GAIN_A: begin
          if (reg_wdata[25:24] == ssc_pkg::GAIN_AUTO || reg_wdata[25:24] == ssc_pkg::GAIN_MANUAL)
            next_tune_a = reg_wdata[25:24];
          if (tune_a == ssc_pkg::GAIN_MANUAL && reg_wdata[7:0] <= ssc_pkg::PGAIN_MAX
              && reg_wdata[15:8] >= ssc_pkg::IGAIN_MIN && reg_wdata[15:8] <= ssc_pkg::IGAIN_MAX) begin
            next_pg_a = reg_wdata[7:0];
            next_ig_a = reg_wdata[15:8];
          end
        end
        ssc_pkg::ADDR_GAIN_B: begin
          if (reg_wdata[25:24] == ssc_pkg::GAIN_AUTO || reg_wdata[25:24] == ssc_pkg::GAIN_MANUAL)
            next_tune_b = reg_wdata[25:24];
          if (tune_b == ssc_pkg::GAIN_MANUAL && reg_wdata[7:0] <= ssc_pkg::PGAIN_MAX
              && reg_wdata[15:8] >= ssc_pkg::IGAIN_MIN && reg_wdata[15:8] <= ssc_pkg::IGAIN_MAX) begin
            next_pg_b = reg_wdata[7:0];
            next_ig_b = reg_wdata[15:8];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode <= 1'b0; polarity <= 1'b0; curve_en <= 1'b0;
      rated_a <= ssc_pkg::RST_RATED; rated_b <= ssc_pkg::RST_RATED;
      ovl_a <= 16'h0000; ovl_b <= 16'h0000;
      full_a <= ssc_pkg::RST_FULL; full_b <= ssc_pkg::RST_FULL; thresh <= 16'h0000;
      dither_amplitude_a <= ssc_pkg::RST_DITHER_AMPLITUDE; dither_amplitude_b <= ssc_pkg::RST_DITHER_AMPLITUDE;
      drate_a <= ssc_pkg::RST_DITHER_RATE; drate_b <= ssc_pkg::RST_DITHER_RATE;
      pwm_a <= ssc_pkg::RST_PWM; pwm_b <= ssc_pkg::RST_PWM;
      tune_a <= ssc_pkg::RST_GAIN_MODE; tune_b <= ssc_pkg::RST_GAIN_MODE;
      pg_a <= ssc_pkg::PGAIN_DEF; ig_a <= ssc_pkg::IGAIN_DEF;
      pg_b <= ssc_pkg::PGAIN_DEF; ig_b <= ssc_pkg::IGAIN_DEF;
    end else begin
      mode <= next_mode; polarity <= next_polarity; curve_en <= next_curve_en;
      rated_a <= next_rated_a; rated_b <= next_rated_b; ovl_a <= next_ovl_a;
      ovl_b <= next_ovl_b; full_a <= next_full_a; full_b <= next_full_b;
      thresh <= next_thresh; dither_amplitude_a <= next_dither_amplitude_a; dither_amplitude_b <= next_dither_amplitude_b;
      drate_a <= next_drate_a; drate_b <= next_drate_b;
      pwm_a <= next_pwm_a; pwm_b <= next_pwm_b; tune_a <= next_tune_a; tune_b <= next_tune_b;
      pg_a <= next_pg_a; ig_a <= next_ig_a; pg_b <= next_pg_b; ig_b <= next_ig_b;
    end
  end

  // ------------------------------------------------------------
  // curve table: entries 0..20 = index -10..10 (single-coil: 10..20 = A, 0..10 = B)
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 21; gi++) begin : g_pt
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          cx[gi] <= 16'(gi * 1000 - 10000); // identity line by default
          cy[gi] <= 16'(gi * 1000 - 10000);
        end else if (pt_idx == 5'(gi)) begin
          if (wr_x && $signed(w_lo) >= -ssc_pkg::COORD_MAX && $signed(w_lo) <= ssc_pkg::COORD_MAX)
            cx[gi] <= w_lo;
          if (wr_y && $signed(w_lo) >= -ssc_pkg::COORD_MAX && $signed(w_lo) <= ssc_pkg::COORD_MAX)
            cy[gi] <= w_lo;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // signal chain (combinational, registered at the output)
  // ------------------------------------------------------------
  ssc_pkg::ssc_pd_in_t pdi;
  assign pdi = pd_in[$bits(ssc_pkg::ssc_pd_in_t)-1:0];

  // piecewise-linear lookup over a half of the table
  function automatic logic signed [15:0] shape(input logic signed [15:0] x, input int lo);
    logic signed [15:0] y;
    int k;
    y = x;
    for (k = 0; k < 10; k++) begin
      if (x >= cx[lo+k] && x <= cx[lo+k+1] && cx[lo+k+1] != cx[lo+k])
        y = 16'((32'(x - cx[lo+k]) * 32'(cy[lo+k+1] - cy[lo+k]))
            / 32'(cx[lo+k+1] - cx[lo+k]) + 32'(cy[lo+k]));
    end
    shape = y;
  endfunction

  // per-channel scaling to percent of rated current, in 0.01 %
  function automatic logic [15:0] scale(input logic [15:0] mag, input logic [15:0] full,
                                        input logic [15:0] ovl, input logic [15:0] thr);
    logic [31:0] t;
    t = 32'h0;
    if (mag > 16'(thr * 16'h000A))
      t = 32'(ovl) * 32'h0A + 32'(mag) * 32'(16'(full * 16'h000A) - 16'(ovl * 16'h000A))
          / 32'h2710;
    scale = (t > 32'(full) * 32'h0A) ? 16'(full * 16'h000A) : t[15:0];
  endfunction

  logic signed [15:0] sp_a, sp_b, sh_a, sh_b;
  logic [15:0] mag_a, mag_b, u_a, u_b;
  always_comb begin
    sp_a = pdi.enable_a ? pdi.setpoint_a : 16'sh0000;
    sp_b = pdi.enable_b ? pdi.setpoint_b : 16'sh0000;
    if (mode == ssc_pkg::MODE_DUAL) begin
      sh_a = (curve_en == ssc_pkg::CURVE_ON) ? shape(sp_a, 0) : sp_a;
      if (sp_a >= 0)
        sh_a = (curve_en == ssc_pkg::CURVE_ON) ? shape(sp_a, 10) : sp_a;
      sh_b = 16'sh0000;
      if ((polarity == ssc_pkg::POL_PLUS) == (sh_a >= 0)) begin
        mag_a = sh_a[15] ? 16'(-sh_a) : sh_a; mag_b = 16'h0000;
      end else begin
        mag_b = sh_a[15] ? 16'(-sh_a) : sh_a; mag_a = 16'h0000;
      end
    end else begin
      // first quadrant only
      sh_a = (sp_a > 0) ? ((curve_en == ssc_pkg::CURVE_ON) ? shape(sp_a, 10) : sp_a) : 16'sh0;
      sh_b = (sp_b > 0) ? ((curve_en == ssc_pkg::CURVE_ON) ? shape(sp_b, 0) : sp_b) : 16'sh0;
      mag_a = sh_a[15] ? 16'h0000 : sh_a;
      mag_b = sh_b[15] ? 16'h0000 : sh_b;
    end
    u_a = scale(mag_a, full_a, ovl_a, thresh);
    u_b = scale(mag_b, full_b, ovl_b, thresh);
  end

  // auto gains: proportional lowered, integral raised below 250 Hz, defaults otherwise
  logic [7:0] apg_a, aig_a, apg_b, aig_b;
  assign apg_a = (pwm_a < ssc_pkg::PWM_STEP_250) ? ssc_pkg::PGAIN_LOW : ssc_pkg::PGAIN_DEF;
  assign aig_a = (pwm_a < ssc_pkg::PWM_STEP_250) ? ssc_pkg::IGAIN_LOW : ssc_pkg::IGAIN_DEF;
  // directional mode: B runs on A's step, so its auto gains follow that step too
  logic [4:0] pwm_b_eff;
  assign pwm_b_eff = (mode == ssc_pkg::MODE_DUAL) ? pwm_a : pwm_b;
  assign apg_b = (pwm_b_eff < ssc_pkg::PWM_STEP_250) ? ssc_pkg::PGAIN_LOW : ssc_pkg::PGAIN_DEF;
  assign aig_b = (pwm_b_eff < ssc_pkg::PWM_STEP_250) ? ssc_pkg::IGAIN_LOW : ssc_pkg::IGAIN_DEF;

  ssc_pkg::ssc_drive_t next_drive;
  ssc_pkg::ssc_pd_out_t next_pd;
  logic [31:0] next_rdata;
  logic signed [15:0] mon_w, mon_u;
  always_comb begin
    next_drive.demand_a        = u_a;
    next_drive.demand_b        = u_b;
    next_drive.dither_ampl_a   = dither_amplitude_a;
    next_drive.dither_rate_a   = drate_a;
    // dual mode shares channel A settings
    next_drive.dither_ampl_b   = (mode == ssc_pkg::MODE_DUAL) ? dither_amplitude_a : dither_amplitude_b;
    next_drive.dither_rate_b   = (mode == ssc_pkg::MODE_DUAL) ? drate_a : drate_b;
    next_drive.pwm_a           = pwm_a;
    next_drive.pwm_b           = pwm_b_eff;
    next_drive.prop_gain_a     = (tune_a == ssc_pkg::GAIN_AUTO) ? apg_a : pg_a;
    next_drive.integral_gain_a = (tune_a == ssc_pkg::GAIN_AUTO) ? aig_a : ig_a;
    next_drive.prop_gain_b     = (tune_b == ssc_pkg::GAIN_AUTO) ? apg_b : pg_b;
    next_drive.integral_gain_b = (tune_b == ssc_pkg::GAIN_AUTO) ? aig_b : ig_b;
    next_pd.status    = 16'h0000;
    next_pd.pin9      = 16'h0000;
    next_pd.pin10     = 16'h0000;
    next_pd.current_a = meas_current_a;
    next_pd.current_b = meas_current_b;
    mon_w = sp_a;
    mon_u = 16'(u_a);
    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      unique case (reg_addr)
        ssc_pkg::ADDR_CONFIG:    next_rdata = {29'h0, curve_en, polarity, mode};
        ssc_pkg::ADDR_RATED_A:   next_rdata = {16'h0, rated_a};
        ssc_pkg::ADDR_RATED_B:   next_rdata = {16'h0, rated_b};
        ssc_pkg::ADDR_OVERLAP:   next_rdata = {ovl_b, ovl_a};
        ssc_pkg::ADDR_FULLSCALE: next_rdata = {full_b, full_a};
        ssc_pkg::ADDR_THRESHOLD: next_rdata = {16'h0, thresh};
        ssc_pkg::ADDR_DITHER_A:  next_rdata = {dither_amplitude_a, drate_a};
        ssc_pkg::ADDR_DITHER_B:  next_rdata = {dither_amplitude_b, drate_b};
        ssc_pkg::ADDR_PWM:       next_rdata = {11'h0, pwm_b, 11'h0, pwm_a};
        ssc_pkg::ADDR_GAIN_A:    next_rdata = {6'h0, tune_a, 8'h0, next_drive.integral_gain_a,
                                               next_drive.prop_gain_a};
        ssc_pkg::ADDR_GAIN_B:    next_rdata = {6'h0, tune_b, 8'h0, next_drive.integral_gain_b,
                                               next_drive.prop_gain_b};
        ssc_pkg::ADDR_PD_OUT:    next_rdata = {meas_current_b, meas_current_a};
        ssc_pkg::ADDR_MON_W:     next_rdata = {sp_b, mon_w};
        ssc_pkg::ADDR_MON_U:     next_rdata = {u_b, mon_u};
        default: begin
          if (reg_addr >= ssc_pkg::ADDR_CURVE_X && reg_addr < ssc_pkg::ADDR_CURVE_Y
              && pt_idx <= 5'h14)
            next_rdata = {16'h0, cx[pt_idx]};
          else if (reg_addr >= ssc_pkg::ADDR_CURVE_Y && reg_addr < ssc_pkg::ADDR_CURVE_END
                   && pt_idx <= 5'h14)
            next_rdata = {16'h0, cy[pt_idx]};
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive     <= '0;
      pd_out    <= '0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      drive     <= next_drive;
      pd_out    <= next_pd;
      reg_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_full_cap;
    @(posedge clk_sys) disable iff (!resetn)
      drive.demand_a <= 16'($past(full_a) * 16'h000A);
  endproperty
  a_full_cap: assert property (p_full_cap) else $error("demand above full scale");
  property p_auto_gain;
    @(posedge clk_sys) disable iff (!resetn)
      (tune_a == ssc_pkg::GAIN_AUTO && pwm_a >= ssc_pkg::PWM_STEP_250)
      |=> drive.prop_gain_a == ssc_pkg::PGAIN_DEF;
  endproperty
  a_auto_gain: assert property (p_auto_gain) else $error("auto gain wrong");
  property p_rated_rng;
    @(posedge clk_sys) disable iff (!resetn)
      rated_a >= ssc_pkg::RATED_MIN && rated_a <= ssc_pkg::RATED_MAX
      && rated_b >= ssc_pkg::RATED_MIN && rated_b <= ssc_pkg::RATED_MAX;
  endproperty
  a_rated_rng: assert property (p_rated_rng) else $error("rated out of range");
  // directional mode: one valve, so only one coil may carry demand
  property p_one_coil;
    @(posedge clk_sys) disable iff (!resetn)
      (mode == ssc_pkg::MODE_DUAL)
      |=> (drive.demand_a == 16'sh0000 || drive.demand_b == 16'sh0000);
  endproperty
  a_one_coil: assert property (p_one_coil) else $error("both coils driven");
  property p_swap;
    @(posedge clk_sys) disable iff (!resetn)
      (mode == ssc_pkg::MODE_DUAL && polarity != ssc_pkg::POL_PLUS
       && curve_en != ssc_pkg::CURVE_ON && pdi.enable_a && pdi.setpoint_a > 16'sh0000)
      |=> drive.demand_a == 16'sh0000;
  endproperty
  a_swap: assert property (p_swap) else $error("swapped polarity drives coil A");
  sequence s_manual_a;
    tune_a == ssc_pkg::GAIN_MANUAL;
  endsequence
  property p_manual_gain;
    @(posedge clk_sys) disable iff (!resetn)
      s_manual_a |=> drive.prop_gain_a == $past(pg_a) && drive.integral_gain_a == $past(ig_a);
  endproperty
  a_manual_gain: assert property (p_manual_gain) else $error("manual gains not applied");
  property p_pwm_shared;
    @(posedge clk_sys) disable iff (!resetn)
      (mode == ssc_pkg::MODE_DUAL) |=> drive.pwm_b == drive.pwm_a;
  endproperty
  a_pwm_shared: assert property (p_pwm_shared) else $error("pwm step not shared");
endmodule // ssc_top

// file: test/ssc_link_master.sv
// cyclic master model: sends setpoint frames, collects status frames
// assumes the bench sets the setpoint and enable as plain levels
`timescale 1ns/1ps
module ssc_link_master (
  // clock
  input  wire logic               clk_sys,
  // bench side
  input  wire logic signed [15:0] sp_a,
  input  wire logic               en_a,
  output logic        [79:0]      pd_seen,
  // device side
  output logic        [47:0]      pd_in,
  input  wire logic   [79:0]      pd_out
);
  ssc_pkg::ssc_pd_in_t frame;
  always_comb begin
    frame            = '0;
    frame.setpoint_a = sp_a;
    frame.enable_a   = en_a;
  end
  // whole frames each cycle, unused upper bits of the 6 bytes held at zero
  always_ff @(posedge clk_sys) begin
    pd_in   <= {14'h0000, frame};
    pd_seen <= pd_out;
  end
endmodule // ssc_link_master

// file: test/tb.sv
// testbench for ssc_top: register port, drive and process data checks
// assumes ssc_link_master stands in for the cyclic master
`timescale 1ns/1ps
module tb;
  logic                clk_sys   = 1'b0;
  logic                resetn    = 1'b0;
  logic [7:0]          reg_addr  = 8'h00;
  logic [31:0]         reg_wdata = 32'h0000_0000;
  logic                reg_write = 1'b0;
  logic                reg_read  = 1'b0;
  logic [31:0]         reg_rdata;
  logic signed [15:0]  sp_a      = 16'sh0000;
  logic                en_a      = 1'b0;
  logic [15:0]         cur_a     = 16'h0000;
  logic [15:0]         cur_b     = 16'h0000;
  logic [47:0]         pd_in;
  logic [79:0]         pd_out;
  logic [79:0]         pd_seen;
  ssc_pkg::ssc_drive_t drive;
  int                  n_errors  = 0;
  int                  cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  ssc_top dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pd_in(pd_in),
    .meas_current_a(cur_a), .meas_current_b(cur_b), .pd_out(pd_out), .drive(drive));
  ssc_link_master master (.clk_sys(clk_sys), .sp_a(sp_a), .en_a(en_a), .pd_seen(pd_seen),
    .pd_in(pd_in), .pd_out(pd_out));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask
  // frame in, register, drive out: three edges through the master model
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ssc_pkg::ADDR_RATED_A, {16'h0000, ssc_pkg::RST_RATED});
    settle();
    cmp(drive.pwm_a, ssc_pkg::RST_PWM);
    cmp(drive.prop_gain_a, ssc_pkg::PGAIN_DEF);
    wr(ssc_pkg::ADDR_RATED_A, 32'h0000_01F3);
    rd(ssc_pkg::ADDR_RATED_A, 32'h0000_03E8);
    wr(ssc_pkg::ADDR_RATED_A, 32'h0000_0A29);
    rd(ssc_pkg::ADDR_RATED_A, 32'h0000_03E8);
    wr(ssc_pkg::ADDR_RATED_A, 32'h0000_0A28);
    rd(ssc_pkg::ADDR_RATED_A, 32'h0000_0A28);
    // dither off before the slow steps; rate rounds up to the next step
    wr(ssc_pkg::ADDR_DITHER_A, 32'h0000_00E1);
    rd(ssc_pkg::ADDR_DITHER_A, 32'h0000_00FA);
    // slowest step on A; directional mode makes B follow A
    wr(ssc_pkg::ADDR_PWM, 32'h0007_0000);
    settle();
    cmp({drive.pwm_b, drive.pwm_a}, {5'h00, 5'h00});
    cmp({drive.prop_gain_a, drive.integral_gain_a}, 16'h023C);
    cmp({drive.prop_gain_b, drive.integral_gain_b}, 16'h023C);
    cmp({drive.dither_ampl_a, drive.dither_rate_a}, 32'h0000_00FA);
    cmp({drive.dither_ampl_b, drive.dither_rate_b}, 32'h0000_00FA);
    wr(ssc_pkg::ADDR_PWM, 32'h0007_0014);
    settle();
    cmp(drive.pwm_a, 5'h00);
    // manual tuning first, then manual gains 3 and 80, then an out-of-range gain
    wr(ssc_pkg::ADDR_GAIN_A, 32'h0100_5003);
    wr(ssc_pkg::ADDR_GAIN_A, 32'h0100_5003);
    wr(ssc_pkg::ADDR_GAIN_A, 32'h0100_5F1F);
    settle();
    cmp({drive.prop_gain_a, drive.integral_gain_a}, 16'h0350);
    @(posedge clk_sys);
    sp_a <= 16'sh1388;
    en_a <= 1'b1;
    settle();
    cmp(drive.demand_b, 16'h0000);
    cmp(drive.demand_a, 16'h1388);
    wr(ssc_pkg::ADDR_CONFIG, 32'h0000_0002);
    settle();
    cmp(drive.demand_a, 16'h0000);
    cmp(drive.demand_b, 16'h1388);
    // single-coil mode must ignore the swap and free channel B's step
    wr(ssc_pkg::ADDR_CONFIG, 32'h0000_0003);
    settle();
    cmp(drive.demand_a, 16'h1388);
    cmp({drive.pwm_b, drive.pwm_a}, {5'h07, 5'h00});
    cmp({drive.prop_gain_b, drive.integral_gain_b}, 16'h0728);
    rd(ssc_pkg::ADDR_MON_U, 32'h0000_1388);
    @(posedge clk_sys);
    cur_a <= 16'h0123;
    cur_b <= 16'h0456;
    settle();
    cmp(pd_seen[31:16], 16'h0123);
    cmp(pd_seen[15:0], 16'h0456);
    final_report();
  end
endmodule // tb
